/* File: rtl/cnf_node.sv */
// Message-level bus node: arbitration, framing, acceptance filter, NMT state
`timescale 1ns/10ps

// Overview of operation
// - Dominant zero overrides recessive one; transmitter only releases, bus is wired-AND.
// - Sending one but reading zero in the identifier means arbitration lost; stop at once.
// - Lower identifier wins; loser turns receiver and leaves the winning frame alone.
// - Start only after the bus was seen idle for the idle-bit count.
// - A lost or aborted frame stays pending and retries when the bus is idle again.
// - Acceptance filter passes NMT, SYNC and receive PDO/SDO frames addressed to this node only.
// - A frame is identifier plus at most eight data bytes; longer lengths clamp.
// - Identifier is function code concatenated with the node ID.
// - Node ID is never zero; zero writes are ignored and transmission blocked.
// - Process data frames carry up to eight bytes, each on its own identifier.
// - Transmit and receive process data identifiers are kept as separate sets.
// - Service data selects entries point-to-point at lower priority than process data.
// - NMT frames drive the communication state; state is reported for monitoring.
// - Factory restore returns every parameter to its delivered value.
// - Only 11-bit identifiers; frames flagged as extended are dropped.
// - Service data entries carry a 16-bit index and an 8-bit subindex.
module cnf_node (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus pins, recessive high
  input wire logic can_rx,
  output logic can_tx,
  // Transmit request
  input wire logic tx_valid,
  input wire cnf_pkg::cnf_tx_s tx_req,
  output logic tx_ready,
  output logic tx_done,
  output logic tx_lost,
  // Receive delivery
  output logic rx_valid,
  output cnf_pkg::cnf_rx_s rx_msg,
  // Configuration and state
  input wire logic nid_wr,
  input wire logic [cnf_pkg::NID_W-1:0] nid_val,
  input wire logic restore_req,
  output logic [cnf_pkg::NID_W-1:0] node_id,
  output logic restore_done,
  output cnf_pkg::cnf_nmt_e nmt_state
);
  cnf_pkg::cnf_bus_e st_q, st_d;
  cnf_pkg::cnf_nmt_e nmt_q, nmt_d;
  cnf_pkg::cnf_rx_s rx_q, rx_d;
  cnf_pkg::cnf_tx_s pend_msg_q, pend_msg_d;
  logic [cnf_pkg::TQ_W-1:0] tq_q, tq_d;
  logic [3:0] idle_q, idle_d;
  logic [6:0] bitn_q, bitn_d, nlen_q, nlen_d;
  logic [cnf_pkg::TXV_W-1:0] txv_q, txv_d;
  logic [cnf_pkg::DAT_W-1:0] shr_q, shr_d;
  logic [cnf_pkg::ID_W-1:0] rid_q, rid_d;
  logic [3:0] rlen_q, rlen_d;
  logic [cnf_pkg::NID_W-1:0] nid_q, nid_d;
  logic pend_q, pend_d, txing_q, txing_d, can_tx_q, can_tx_d, rdy_q, rdy_d;
  logic done_q, done_d, lost_q, lost_d, rxv_q, rxv_d, rst_done_q, rst_done_d;
  logic may_send, smp, b;
  logic [3:0] len_now;
  cnf_pkg::cnf_cls_e cls;

  // Transmit gating by communication state; SDO/PDO priority comes from the code itself
  always_comb begin
    case (nmt_q)
      cnf_pkg::NMT_OPER: may_send = 1'b1;
      cnf_pkg::NMT_PREOP: may_send = (pend_msg_q.fc != cnf_pkg::FC_RPDO1 - 4'h1) &&
                                     (pend_msg_q.fc[0] || pend_msg_q.fc == cnf_pkg::FC_HBEAT ||
                                      pend_msg_q.fc == cnf_pkg::FC_RSDO);
      cnf_pkg::NMT_STOPPED: may_send = (pend_msg_q.fc == cnf_pkg::FC_HBEAT);
      default: may_send = 1'b0;
    endcase
  end

  // Acceptance filter on the received identifier
  always_comb begin
    cls = cnf_pkg::CLS_OTHER;
    if (rid_q == '0) begin
      cls = cnf_pkg::CLS_NMT;
    end else if (rid_q == {cnf_pkg::FC_SYNC, 7'h00}) begin
      cls = cnf_pkg::CLS_SYNC;
    end else if (rid_q[6:0] == nid_q) begin
      case (rid_q[10:7])
        cnf_pkg::FC_RPDO1, cnf_pkg::FC_RPDO2,
        cnf_pkg::FC_RPDO3, cnf_pkg::FC_RPDO4: cls = cnf_pkg::CLS_PDO;
        cnf_pkg::FC_RSDO: cls = cnf_pkg::CLS_SDO;
        default: cls = cnf_pkg::CLS_OTHER;
      endcase
    end
  end

  assign smp = (tq_q == cnf_pkg::TQ_SMP);
  assign b = can_rx;
  assign len_now = ({rlen_q[2:0], b} > cnf_pkg::MAX_BYTES) ? cnf_pkg::MAX_BYTES
                                                            : {rlen_q[2:0], b};

  always_comb begin
    st_d = st_q;
    nmt_d = nmt_q;
    rx_d = rx_q;
    pend_msg_d = pend_msg_q;
    tq_d = (tq_q == cnf_pkg::TQ_LAST) ? '0 : tq_q + 1'b1;
    idle_d = idle_q;
    bitn_d = bitn_q;
    nlen_d = nlen_q;
    txv_d = txv_q;
    shr_d = shr_q;
    rid_d = rid_q;
    rlen_d = rlen_q;
    nid_d = nid_q;
    pend_d = pend_q;
    txing_d = txing_q;
    can_tx_d = can_tx_q;
    done_d = 1'b0;
    lost_d = 1'b0;
    rxv_d = 1'b0;
    rst_done_d = 1'b0;
    if (nmt_q == cnf_pkg::NMT_INIT) begin
      nmt_d = cnf_pkg::NMT_PREOP;
    end
    if (tx_valid && rdy_q) begin
      pend_d = 1'b1;
      pend_msg_d = tx_req;
    end
    case (st_q)
      cnf_pkg::S_WAIT: begin
        can_tx_d = 1'b1;
        if (smp) begin
          idle_d = b ? idle_q + 4'h1 : 4'h0;
          if (b && idle_q + 4'h1 == cnf_pkg::IDLE_BITS) begin
            st_d = cnf_pkg::S_IDLE;
          end
        end
      end
      cnf_pkg::S_IDLE: begin
        tq_d = '0;
        bitn_d = '0;
        if (pend_q && may_send && nid_q != '0) begin
          st_d = cnf_pkg::S_FRAME;
          txing_d = 1'b1;
          can_tx_d = 1'b0;
          txv_d = {1'b0, pend_msg_q.fc, nid_q, 1'b0, pend_msg_q.dlc,
                   pend_msg_q.data};
        end else if (!b) begin
          st_d = cnf_pkg::S_FRAME;
          txing_d = 1'b0;
          tq_d = cnf_pkg::TQ_W'(1);
        end
      end
      cnf_pkg::S_FRAME: begin
        if (smp) begin
          bitn_d = bitn_q + 7'h01;
          txv_d = {txv_q[cnf_pkg::TXV_W-2:0], 1'b1};
          if (bitn_q >= cnf_pkg::BIT_ID_FIRST && bitn_q <= cnf_pkg::BIT_ID_LAST) begin
            rid_d = {rid_q[cnf_pkg::ID_W-2:0], b};
          end
          if (bitn_q > cnf_pkg::BIT_FMT && bitn_q <= cnf_pkg::BIT_LEN_LAST) begin
            rlen_d = {rlen_q[2:0], b};
          end
          if (bitn_q > cnf_pkg::BIT_LEN_LAST) begin
            shr_d = {shr_q[cnf_pkg::DAT_W-2:0], b};
          end
          if (bitn_q == cnf_pkg::BIT_LEN_LAST) begin
            nlen_d = cnf_pkg::HDR_BITS + {len_now, 3'h0};
          end
          if (txing_q && txv_q[cnf_pkg::TXV_W-1] && !b &&
              bitn_q >= cnf_pkg::BIT_ID_FIRST && bitn_q <= cnf_pkg::BIT_ID_LAST) begin
            txing_d = 1'b0;
            can_tx_d = 1'b1;
            lost_d = 1'b1;
          end else if ((txing_q && txv_q[cnf_pkg::TXV_W-1] != b) ||
                       (bitn_q == cnf_pkg::BIT_FMT && b)) begin
            st_d = cnf_pkg::S_WAIT;
            txing_d = 1'b0;
            can_tx_d = 1'b1;
            idle_d = 4'h0;
          end else if ((bitn_q == cnf_pkg::BIT_LEN_LAST && len_now == 4'h0) ||
                       (bitn_q > cnf_pkg::BIT_LEN_LAST && bitn_q + 7'h01 == nlen_q)) begin
            st_d = cnf_pkg::S_WAIT;
            txing_d = 1'b0;
            can_tx_d = 1'b1;
            idle_d = 4'h0;
            if (txing_q) begin
              done_d = 1'b1;
              pend_d = 1'b0;
            end else if (cls != cnf_pkg::CLS_OTHER) begin
              rxv_d = 1'b1;
              rx_d.cls = cls;
              rx_d.cob = rid_q;
              rx_d.dlc = (bitn_q == cnf_pkg::BIT_LEN_LAST) ? 4'h0 : nlen_q[6:3] - 4'h2;
              rx_d.data = (bitn_q == cnf_pkg::BIT_LEN_LAST) ? '0 :
                          shr_d << {cnf_pkg::MAX_BYTES - (nlen_q[6:3] - 4'h2), 3'h0};
              // Index follows the command byte, low byte first, then the subindex
              rx_d.index = {rx_d.data[47:40], rx_d.data[55:48]};
              rx_d.subidx = rx_d.data[39:32];
              if (cls == cnf_pkg::CLS_NMT &&
                  (rx_d.data[55:48] == 8'h00 || rx_d.data[55:48] == {1'b0, nid_q})) begin
                case (rx_d.data[63:56])
                  cnf_pkg::NMT_CMD_START: nmt_d = cnf_pkg::NMT_OPER;
                  cnf_pkg::NMT_CMD_STOP: nmt_d = cnf_pkg::NMT_STOPPED;
                  cnf_pkg::NMT_CMD_PREOP: nmt_d = cnf_pkg::NMT_PREOP;
                  cnf_pkg::NMT_CMD_RST_NODE, cnf_pkg::NMT_CMD_RST_COMM:
                    nmt_d = cnf_pkg::NMT_INIT;
                  default: nmt_d = nmt_q;
                endcase
              end
            end
          end
        end else if (tq_q == cnf_pkg::TQ_LAST) begin
          can_tx_d = txing_q ? txv_q[cnf_pkg::TXV_W-1] : 1'b1;
        end
      end
      default: st_d = cnf_pkg::S_WAIT;
    endcase
    // A zero ID would collide with the broadcast NMT code, so it is never stored
    if (nid_wr && nid_val != '0) begin
      nid_d = nid_val;
    end
    if (restore_req) begin
      nid_d = cnf_pkg::DEF_NODE_ID;
      rst_done_d = 1'b1;
    end
    rdy_d = !pend_d;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= cnf_pkg::S_WAIT;
      nmt_q <= cnf_pkg::NMT_INIT;
      rx_q <= '0;
      pend_msg_q <= '0;
      tq_q <= '0;
      idle_q <= 4'h0;
      bitn_q <= 7'h00;
      nlen_q <= 7'h00;
      txv_q <= '1;
      shr_q <= '0;
      rid_q <= '0;
      rlen_q <= 4'h0;
      nid_q <= cnf_pkg::DEF_NODE_ID;
      pend_q <= 1'b0;
      txing_q <= 1'b0;
      can_tx_q <= 1'b1;
      rdy_q <= 1'b0;
      done_q <= 1'b0;
      lost_q <= 1'b0;
      rxv_q <= 1'b0;
      rst_done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      nmt_q <= nmt_d;
      rx_q <= rx_d;
      pend_msg_q <= pend_msg_d;
      tq_q <= tq_d;
      idle_q <= idle_d;
      bitn_q <= bitn_d;
      nlen_q <= nlen_d;
      txv_q <= txv_d;
      shr_q <= shr_d;
      rid_q <= rid_d;
      rlen_q <= rlen_d;
      nid_q <= nid_d;
      pend_q <= pend_d;
      txing_q <= txing_d;
      can_tx_q <= can_tx_d;
      rdy_q <= rdy_d;
      done_q <= done_d;
      lost_q <= lost_d;
      rxv_q <= rxv_d;
      rst_done_q <= rst_done_d;
    end
  end

  assign can_tx = can_tx_q;
  assign tx_ready = rdy_q;
  assign tx_done = done_q;
  assign tx_lost = lost_q;
  assign rx_valid = rxv_q;
  assign rx_msg = rx_q;
  assign node_id = nid_q;
  assign restore_done = rst_done_q;
  assign nmt_state = nmt_q;

  a_nid_nonzero: assert property (@(posedge sys_clk) disable iff (rst)
    nid_q != '0) else $error("node id is zero");
  a_lost_release: assert property (@(posedge sys_clk) disable iff (rst)
    lost_q |-> can_tx_q && !txing_q) else $error("still driving after loss");
  a_wait_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == cnf_pkg::S_WAIT |-> can_tx_q) else $error("driving while bus busy");
  a_retry_held: assert property (@(posedge sys_clk) disable iff (rst)
    lost_q |-> pend_q && !rdy_q) else $error("pending frame dropped on loss");
  a_filter_pass: assert property (@(posedge sys_clk) disable iff (rst)
    rxv_q |-> rx_q.cls != cnf_pkg::CLS_OTHER &&
              (rx_q.cob == '0 || rx_q.cob == {cnf_pkg::FC_SYNC, 7'h00} ||
               rx_q.cob[6:0] == nid_q)) else $error("frame passed for another node");
  a_len_max: assert property (@(posedge sys_clk) disable iff (rst)
    rxv_q |-> rx_q.dlc <= 4'h8) else $error("frame longer than 8 bytes");
  a_cob_form: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(txing_q) |-> txv_q[79:69] == {pend_msg_q.fc, nid_q} && !can_tx_q)
    else $error("identifier not fc plus node id");
  a_factory: assert property (@(posedge sys_clk) disable iff (rst)
    restore_req |=> nid_q == cnf_pkg::DEF_NODE_ID && rst_done_q)
    else $error("restore did not apply defaults");
  a_nmt_boot: assert property (@(posedge sys_clk) disable iff (rst)
    nmt_q == cnf_pkg::NMT_INIT |=> nmt_q == cnf_pkg::NMT_PREOP)
    else $error("init not left");
endmodule // cnf_node

/* File: rtl/cnf_pkg.sv */
// Constants, types and frame layout for the message-level bus node
package cnf_pkg;
  // Bit timing
  localparam int CLK_NS = 40;
  localparam int BIT_NS = 4000;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam int TQ_W = 7;
  localparam logic [TQ_W-1:0] TQ_LAST = TQ_W'(BIT_CYC - 1);
  localparam logic [TQ_W-1:0] TQ_SMP = TQ_W'((BIT_CYC * 3) / 4);
  localparam logic [3:0] IDLE_BITS = 4'hB;
  // Frame layout: SOF, 11 id bits, format bit, 4 length bits, data
  localparam int ID_W = 11;
  localparam int NID_W = 7;
  localparam int DAT_W = 64;
  localparam int TXV_W = 81;
  localparam logic [6:0] BIT_ID_FIRST = 7'h01;
  localparam logic [6:0] BIT_ID_LAST = 7'h0B;
  localparam logic [6:0] BIT_FMT = 7'h0C;
  localparam logic [6:0] BIT_LEN_LAST = 7'h10;
  localparam logic [6:0] HDR_BITS = 7'h11;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  // Function codes
  localparam logic [3:0] FC_NMT = 4'h0;
  localparam logic [3:0] FC_SYNC = 4'h1;
  localparam logic [3:0] FC_RPDO1 = 4'h4;
  localparam logic [3:0] FC_RPDO2 = 4'h6;
  localparam logic [3:0] FC_RPDO3 = 4'h8;
  localparam logic [3:0] FC_RPDO4 = 4'hA;
  localparam logic [3:0] FC_TSDO = 4'hB;
  localparam logic [3:0] FC_RSDO = 4'hC;
  localparam logic [3:0] FC_HBEAT = 4'hE;
  // Network management commands and the default node ID
  localparam logic [7:0] NMT_CMD_START = 8'h01;
  localparam logic [7:0] NMT_CMD_STOP = 8'h02;
  localparam logic [7:0] NMT_CMD_PREOP = 8'h80;
  localparam logic [7:0] NMT_CMD_RST_NODE = 8'h81;
  localparam logic [7:0] NMT_CMD_RST_COMM = 8'h82;
  localparam logic [NID_W-1:0] DEF_NODE_ID = 7'h10;

  typedef enum logic [1:0] {NMT_INIT, NMT_PREOP, NMT_OPER, NMT_STOPPED} cnf_nmt_e;
  typedef enum logic [2:0] {CLS_NMT, CLS_SYNC, CLS_PDO, CLS_SDO, CLS_OTHER} cnf_cls_e;
  typedef enum logic [1:0] {S_WAIT, S_IDLE, S_FRAME} cnf_bus_e;

  typedef struct packed {
    logic [3:0] fc;
    logic [3:0] dlc;
    logic [DAT_W-1:0] data;
  } cnf_tx_s;

  typedef struct packed {
    cnf_cls_e cls;
    logic [ID_W-1:0] cob;
    logic [3:0] dlc;
    logic [DAT_W-1:0] data;
    logic [15:0] index;
    logic [7:0] subidx;
  } cnf_rx_s;
endpackage

/* File: tb/cnf_peer.sv */
// Far-side bus node model: sends one frame, hard-syncs or starts alone, backs off on loss
`timescale 1ns/10ps
module cnf_peer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus, recessive high
  input wire logic bus_lvl,
  output logic peer_tx,
  // Frame request, bits left-aligned
  input wire logic go,
  input wire logic follow,
  input wire logic [80:0] frame,
  input wire logic [6:0] nbits,
  output logic busy,
  output logic lost
);
  logic arm_q;
  logic [80:0] sh_q;
  logic [6:0] left_q;
  logic [6:0] ph_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arm_q <= 1'b0;
      busy <= 1'b0;
      lost <= 1'b0;
      peer_tx <= 1'b1;
      ph_q <= '0;
    end else if (go) begin
      sh_q <= frame;
      left_q <= nbits;
      lost <= 1'b0;
      busy <= 1'b1;
      arm_q <= follow;
      peer_tx <= follow | frame[80];
      ph_q <= '0;
    end else if (arm_q) begin
      // Joins a start bit already on the bus, so both nodes contend bit by bit
      if (!bus_lvl) begin
        arm_q <= 1'b0;
        peer_tx <= sh_q[80];
        ph_q <= 7'h01;
      end
    end else if (busy) begin
      ph_q <= (ph_q == cnf_pkg::TQ_LAST) ? '0 : ph_q + 7'h01;
      if (ph_q == cnf_pkg::TQ_SMP && sh_q[80] && !bus_lvl) begin
        // Recessive sent, dominant seen: release at once, winner goes on
        busy <= 1'b0;
        lost <= 1'b1;
        peer_tx <= 1'b1;
      end else if (ph_q == cnf_pkg::TQ_LAST) begin
        // Identifier and data leave MSB first
        sh_q <= sh_q << 1;
        left_q <= left_q - 7'h01;
        busy <= (left_q != 7'h01);
        peer_tx <= (left_q == 7'h01) | sh_q[79];
      end
    end
  end
endmodule // cnf_peer

/* File: tb/cnf_node_tb.sv */
// Self-checking bench for the bus node
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module cnf_node_tb;
  // Command, target, expected state; the last entry leaves the node operational
  localparam logic [19:0] NMT_SEQ [8] = '{20'h02003, 20'h81101, 20'h01051, 20'h01002,
    20'h82001, 20'h01102, 20'h80001, 20'h01002};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tx_valid = 1'b0, nid_wr = 1'b0, restore_req = 1'b0, p_go = 1'b0, p_fol = 1'b0;
  logic [6:0] nid_val = 7'h00, p_nbits = 7'h11;
  logic [80:0] p_frame = '1;
  cnf_pkg::cnf_tx_s tx_req = '0;
  logic can_tx, tx_ready, tx_done, tx_lost, rx_valid, restore_done, p_tx, p_busy, p_lost;
  logic [6:0] node_id;
  cnf_pkg::cnf_rx_s rx_msg;
  cnf_pkg::cnf_nmt_e nmt_state;
  int bad_count = 0, n_tests = 0, cyc = 0, rx_n = 0, done_n = 0, lost_n = 0;
  // Wired-AND, zero dominant
  wire logic bus = can_tx & p_tx;
  always #20 sys_clk = ~sys_clk;
  cnf_node dut (.sys_clk(sys_clk), .rst(rst), .can_rx(bus), .can_tx(can_tx),
    .tx_valid(tx_valid), .tx_req(tx_req), .tx_ready(tx_ready), .tx_done(tx_done),
    .tx_lost(tx_lost), .rx_valid(rx_valid), .rx_msg(rx_msg), .nid_wr(nid_wr),
    .nid_val(nid_val), .restore_req(restore_req), .node_id(node_id),
    .restore_done(restore_done), .nmt_state(nmt_state));
  cnf_peer peer (.sys_clk(sys_clk), .rst(rst), .bus_lvl(bus), .peer_tx(p_tx), .go(p_go),
    .follow(p_fol), .frame(p_frame), .nbits(p_nbits), .busy(p_busy), .lost(p_lost));
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling sits above the roughly 75k cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_valid === 1'b1) rx_n++;
    if (tx_done === 1'b1) done_n++;
    if (tx_lost === 1'b1) lost_n++;
    if (cyc == 96000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  function automatic logic [80:0] mk(input logic [10:0] id, input logic fmt,
      input logic [3:0] dlc, input logic [63:0] d);
    return {1'b0, id, fmt, dlc, d};
  endfunction
  // Twelve idle bits first, so every receiver has seen the bus free
  task automatic psend(input logic [10:0] id, input logic fmt, input logic [3:0] dlc,
      input logic [63:0] d, input logic fol);
    cy(1200);
    p_frame <= mk(id, fmt, dlc, d);
    p_nbits <= 7'(17 + 8 * dlc);
    p_fol <= fol;
    p_go <= 1'b1;
    cy(1);
    p_go <= 1'b0;
    cy(1);
  endtask
  task automatic pwait();
    for (int k = 0; k < 9000 && p_busy === 1'b1; k++) cy(1);
    cy(5);
  endtask
  task automatic req(input logic [3:0] fc, input logic [3:0] dlc, input logic [63:0] d);
    tx_req <= '{fc: fc, dlc: dlc, data: d};
    tx_valid <= 1'b1;
    cy(1);
    tx_valid <= 1'b0;
  endtask
  task automatic wait_done(input int d0);
    for (int k = 0; k < 5000 && done_n == d0; k++) cy(1);
  endtask
  task automatic set_nid(input logic [6:0] v);
    nid_val <= v;
    nid_wr <= 1'b1;
    cy(1);
    nid_wr <= 1'b0;
    cy(2);
  endtask
  task automatic t_cfg();
    `CHK(node_id, 7'h10)
    `CHK(can_tx, 1'b1)
    set_nid(7'h00);
    `CHK(node_id, 7'h10)
    set_nid(7'h22);
    `CHK(node_id, 7'h22)
    restore_req <= 1'b1;
    cy(1);
    restore_req <= 1'b0;
    #1;
    `CHK(restore_done, 1'b1)
    cy(1);
    `CHK(node_id, 7'h10)
    $display("t_cfg done");
  endtask
  task automatic t_rx();
    int n0;
    n0 = rx_n;
    psend({cnf_pkg::FC_RPDO1, 7'h10}, 1'b0, 4'h2, 64'hBEEF_0000_0000_0000, 1'b0);
    pwait();
    `CHK(rx_n, n0 + 1)
    `CHK(rx_msg.cob, 11'h210)
    `CHK(rx_msg.cls, cnf_pkg::CLS_PDO)
    `CHK(rx_msg.data, 64'hBEEF_0000_0000_0000)
    `CHK(rx_msg.dlc, 4'h2)
    psend({cnf_pkg::FC_RPDO1, 7'h11}, 1'b0, 4'h1, 64'h0, 1'b0);
    pwait();
    // A transmit-side process data code on our own ID is not for us
    psend({4'h3, 7'h10}, 1'b0, 4'h1, 64'h0, 1'b0);
    pwait();
    `CHK(rx_n, n0 + 1)
    psend({cnf_pkg::FC_RPDO1, 7'h10}, 1'b1, 4'h0, 64'h0, 1'b0);
    pwait();
    `CHK(rx_n, n0 + 1)
    psend(11'h080, 1'b0, 4'h0, 64'h0, 1'b0);
    pwait();
    `CHK(rx_msg.cls, cnf_pkg::CLS_SYNC)
    psend({cnf_pkg::FC_RSDO, 7'h10}, 1'b0, 4'h4, 64'h4018_1002_0000_0000, 1'b0);
    pwait();
    `CHK(rx_msg.cls, cnf_pkg::CLS_SDO)
    `CHK(rx_msg.dlc, 4'h4)
    `CHK(rx_msg.index, 16'h1018)
    `CHK(rx_msg.subidx, 8'h02)
    $display("t_rx done");
  endtask
  task automatic t_nmt();
    for (int i = 0; i < 8; i++) begin
      psend(11'h000, 1'b0, 4'h2, {NMT_SEQ[i][19:4], 48'h0}, 1'b0);
      pwait();
      `CHK(nmt_state, cnf_pkg::cnf_nmt_e'(NMT_SEQ[i][1:0]))
    end
    $display("t_nmt done");
  endtask
  task automatic t_tx();
    logic [80:0] exp;
    logic [24:0] got;
    int d0;
    d0 = done_n;
    exp = mk({4'h3, 7'h10}, 1'b0, 4'h1, 64'hA500_0000_0000_0000);
    req(4'h3, 4'h1, 64'hA500_0000_0000_0000);
    for (int k = 0; k < 3000 && can_tx !== 1'b0; k++) cy(1);
    cy(50);
    for (int i = 24; i >= 0; i--) begin
      got[i] = can_tx;
      cy(100);
    end
    `CHK(got, exp[80:56])
    `CHK(done_n, d0 + 1)
    `CHK(tx_ready, 1'b1)
    $display("t_tx done");
  endtask
  // Peer with the lower identifier contends from the same start bit
  task automatic t_arb();
    int l0, d0, r0;
    l0 = lost_n;
    d0 = done_n;
    r0 = rx_n;
    psend(11'h001, 1'b0, 4'h0, 64'h0, 1'b1);
    req(4'h3, 4'h0, 64'h0);
    pwait();
    `CHK(lost_n, l0 + 1)
    `CHK(p_lost, 1'b0)
    `CHK(rx_n, r0)
    wait_done(d0);
    `CHK(done_n, d0 + 1)
    $display("t_arb done");
  endtask
  task automatic t_busy();
    int bad, d0;
    bad = 0;
    d0 = done_n;
    psend(11'h123, 1'b0, 4'h2, 64'h0, 1'b0);
    req(4'h5, 4'h0, 64'h0);
    for (int k = 0; k < 4000 && p_busy === 1'b1; k++) begin
      if (can_tx !== 1'b1) bad++;
      cy(1);
    end
    `CHK(bad, 0)
    wait_done(d0);
    `CHK(done_n, d0 + 1)
    $display("t_busy done");
  endtask
  initial begin
    cy(16);
    rst <= 1'b0;
    cy(2);
    t_cfg();
    t_rx();
    t_nmt();
    t_tx();
    t_arb();
    t_busy();
    close_out();
  end
endmodule // cnf_node_tb
